// file: sim/lfr_core_properties.sv
// port assertions for the lin frame block
`timescale 1ns/100ps
module lfr_core_chk (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_arvalid,
    input wire logic        i_bready,
    input wire logic        i_rready,
    input wire logic        o_awready,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic [3:0]  o_tx_len,
    input wire logic [3:0]  o_rx_len,
    input wire logic [5:0]  o_frame_id,
    input wire logic        o_lin_mode,
    input wire logic        o_cksum_classic
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // frame fields stay in their documented ranges
    tx_clamp_a: assert property (o_tx_len <= 4'h8)
        else $error("tx byte count above eight");
    rx_clamp_a: assert property (o_rx_len <= 4'h8)
        else $error("rx byte count above eight");
    uart_quiet_a: assert property (!o_lin_mode |->
        o_tx_len == 4'h0 && o_rx_len == 4'h0 && o_frame_id == 6'h00
        && !o_cksum_classic) else $error("uart mode uses frame fields");
    legacy_id_a: assert property (o_cksum_classic |->
        o_lin_mode && o_frame_id[5:4] == 2'b00)
        else $error("legacy identifier wider than four bits");
    reset_out_a: assert property ($fell(i_rst) |-> o_lin_mode
        && !o_cksum_classic && o_tx_len == 4'h0 && o_frame_id == 6'h00)
        else $error("outputs not at reset state");
    // bus answers stand until taken; a stalled master must see no change
    bresp_hold_a: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
    rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    rd_block_a: assert property (o_rvalid |-> !o_arready)
        else $error("read taken while answer pending");
    wr_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while answer pending");
endmodule

bind lfr_core lfr_core_chk u_chk (
    .i_mclk          (i_mclk),
    .i_rst           (i_rst),
    .i_arvalid       (i_arvalid),
    .i_bready        (i_bready),
    .i_rready        (i_rready),
    .o_awready       (o_awready),
    .o_wready        (o_wready),
    .o_bresp         (o_bresp),
    .o_bvalid        (o_bvalid),
    .o_arready       (o_arready),
    .o_rdata         (o_rdata),
    .o_rvalid        (o_rvalid),
    .o_tx_len        (o_tx_len),
    .o_rx_len        (o_rx_len),
    .o_frame_id      (o_frame_id),
    .o_lin_mode      (o_lin_mode),
    .o_cksum_classic (o_cksum_classic)
);

// file: sim/lfr_lin_node.sv
// remote lin node model: header fields of the last lin frame it saw
`timescale 1ns/100ps
module lfr_lin_node (
    input  wire logic       i_mclk,
    input  wire logic       i_lin_mode,
    input  wire logic [3:0] i_tx_len,
    input  wire logic [5:0] i_frame_id,
    output logic [9:0]      o_last_hdr
);
    // uart traffic carries no header, so the last one is kept
    always_ff @(posedge i_mclk) begin
        if (i_lin_mode) begin
            o_last_hdr <= {i_tx_len, i_frame_id};
        end
    end
endmodule

// file: sim/tb_lfr_core.sv
// self-checking bench for the lin frame block over axi4-lite
`timescale 1ns/100ps
`include "lfr_params.svh"
module tb_lfr_core;
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, lin, ckc;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb, txl, rxl;
    logic [1:0]  bresp, rresp, r;
    logic [5:0]  fid;
    logic [9:0]  hdr;
    int          err_total, n_compared;
    localparam logic [7:0] SA [6] = '{`LFR_OFS_INTEN, `LFR_OFS_BUFSEL,
        `LFR_OFS_BAUD_LO, `LFR_OFS_BAUD_HI, `LFR_OFS_LENGTH, `LFR_OFS_DATA};
    localparam logic [7:0] SW [6] = '{8'hff, 8'ha5, 8'h12, 8'h34,
        8'h44, 8'h77};
    localparam logic [7:0] SE [6] = '{8'hf0, 8'ha0, 8'h12, 8'h34,
        8'h00, 8'h00};

    lfr_core dut (.i_mclk(clk), .i_rst(rst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .o_tx_len(txl), .o_rx_len(rxl),
        .o_frame_id(fid), .o_lin_mode(lin), .o_cksum_classic(ckc));
    lfr_lin_node node (.i_mclk(clk), .i_lin_mode(lin), .i_tx_len(txl),
        .i_frame_id(fid), .o_last_hdr(hdr));

    // 200 mhz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("mismatches %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // ready is judged at the falling edge, so the rising edge sees it held
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ha, hw, hb;
        int   n;
        n = 0;
        awaddr  <= a;
        wdata   <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r  = bresp;
            n++;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (n == 3) bready <= 1'b1;
        end while (!hb && n < 100);
        if (!hb) err_total++;
    endtask

    task automatic rd(input logic [7:0] a);
        logic ha, hr;
        int   n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            d  = rdata;
            r  = rresp;
            n++;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (n == 3) rready <= 1'b1;
        end while (!hr && n < 100);
        if (!hr) err_total++;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask

    // outputs settle one edge after the register update
    task automatic pchk(input logic [15:0] e);
        repeat (2) @(negedge clk);
        chk({16'h0, lin, ckc, txl, rxl, fid}, {16'h0, e});
        @(posedge clk);
    endtask

    function automatic logic [7:0] idv(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[4] ^ i[2] ^ i[1] ^ i[0], i};
    endfunction

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #20000;
        err_total++;
        finish_test();
    end

    initial begin
        err_total  = 0;
        n_compared = 0;
        {rst, bready, rready} = 3'b111;
        {awvalid, wvalid, arvalid} = 3'b000;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++) rchk(8'(i * 4),
            (i == 4) ? 32'h20 : (i == 8) ? 32'h80 : 32'h0);
        wr(`LFR_OFS_LENGTH, 8'hf3);
        pchk({2'b10, 4'h8, 4'h3, 6'h00});
        wr(`LFR_OFS_LENGTH, 8'h59);
        rchk(`LFR_OFS_LENGTH, 32'h59);
        // a write without its low byte lane is dropped
        wstrb <= 4'h0;
        wr(`LFR_OFS_LENGTH, 8'h11);
        wstrb <= 4'hf;
        for (int k = 0; k < 64; k += 21) begin
            wr(`LFR_OFS_IDENT, 8'(k));
            rchk(`LFR_OFS_IDENT, {24'h0, idv(6'(k))});
            pchk({2'b10, 4'h5, 4'h8, 6'(k)});
            chk({22'h0, hdr}, {22'h0, 4'h5, 6'(k)});
        end
        wr(`LFR_OFS_CTRL, 8'h08);
        for (int c = 0; c < 4; c++) begin
            wr(`LFR_OFS_IDENT, {2'h0, 2'(c), 4'h9});
            rd(`LFR_OFS_DECODE);
            chk(d & 32'hfff0, {16'h0, (c < 2) ? 4'h2 : (c == 2) ? 4'h4
                : 4'h8, 6'h09, 2'b11, 4'h0});
        end
        pchk({2'b11, 4'h5, 4'h8, 6'h09});
        wr(`LFR_OFS_CTRL, 8'h0c);
        pchk(16'h0);
        rchk(`LFR_OFS_IDENT, 32'h39);
        for (int i = 0; i < 6; i++) wr(SA[i], SW[i]);
        wr(`LFR_OFS_CTRL, 8'h8c);
        for (int i = 0; i < 6; i++) begin
            rchk(SA[i], {24'h0, SE[i]});
        end
        rchk(`LFR_OFS_CTRL, 32'h0);
        rchk(`LFR_OFS_IDENT, 32'h80);
        pchk(16'h8000);
        // unmapped place, with the master stalling both answers
        bready <= 1'b0;
        wr(8'h30, 8'h11);
        chk({30'h0, r}, 32'h2);
        rready <= 1'b0;
        rd(8'h30);
        chk({d[29:0], r}, 32'h2);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rchk(SA[i], 32'h0);
        finish_test();
    end
endmodule

// file: src/lfr_core.sv
// lin/uart reset handling, protocol select, length and identifier fields
`timescale 1ns/100ps
`include "lfr_params.svh"

// What this block does
// - core reset returns whole controller to reset
// - self-clearing soft reset bit, partial reset only
// - either reset zeroes control, status, error, length, data
// - soft reset clears interrupt-enable low nibble only
// - soft reset keeps baud bytes, high nibble undefined
// - soft reset clears buffer-select low nibble only
// - protocol bit: 0 lin 2.1, 1 lin 1.3
// - enhanced checksum 2.1, classic checksum 1.3
// - protocol bit ignored in uart mode
// - tx byte count from length 7:4, max 8
// - rx byte count from length 3:0, max 8
// - uart mode ignores length and identifier fields
// - parity bit 6 is xor of id 4,2,1,0
// - parity bit 7 is inverted xor id 1,3,4,5
// - lin 1.3 length code 00/01=2, 10=4, 11=8
// - lin 1.3 identifier is bits 3:0
// - lin 2.1 identifier is bits 5:0, no length
module lfr_core (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [3:0]       o_tx_len,
    output logic [3:0]       o_rx_len,
    output logic [5:0]       o_frame_id,
    output logic             o_lin_mode,
    output logic             o_cksum_classic
);

    // clamp a length field to eight bytes
    function automatic logic [3:0] lfr_clamp(input logic [3:0] v);
        lfr_clamp = (v > `LFR_LEN_MAX) ? `LFR_LEN_MAX : v;
    endfunction

    // decode a word address; unmapped answers with slverr
    function automatic logic lfr_mapped(input logic [7:0] a);
        lfr_mapped = (a[1:0] == 2'h0) && (a <= `LFR_OFS_DECODE);
    endfunction

    logic [7:0]  controller_control_reg_r;
    logic [7:0]  status_interrupt_reg_r;
    logic [7:0]  interrupt_enable_reg_r;
    logic [7:0]  error_reg_r;
    logic [7:0]  bit_timing_reg_r;
    logic [7:0]  baud_divisor_low_r;
    logic [7:0]  baud_divisor_high_r;
    logic [7:0]  frame_length_control_r;
    logic [5:0]  id_value_r;
    logic [7:0]  buffer_select_reg_r;
    logic [7:0]  data_window_reg_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic        soft_reset_bit;
    logic        wr_go;
    logic        wr_hit;
    logic        wr_ctrl;
    logic        wr_inten;
    logic        wr_bittime;
    logic        wr_baud_lo;
    logic        wr_baud_hi;
    logic        wr_length;
    logic        wr_ident;
    logic        wr_bufsel;
    logic        wr_data;
    logic [7:0]  wbyte;
    logic        legacy_protocol_select;
    logic        uart_mode;
    logic [1:0]  id_parity_bits;
    logic [1:0]  legacy_length_code;
    logic [3:0]  legacy_len;
    logic [7:0]  ident_read;
    logic [3:0]  tx_byte_count;
    logic [3:0]  rx_byte_count;
    logic [31:0] rd_word;
    lfr_pkg::lfr_cksum_t cksum_kind;
    lfr_pkg::lfr_wr_state_t wr_state_r;

    // address and data accepted in either order, one write at a time
    assign o_awready = !aw_held_r && !o_bvalid;
    assign o_wready  = !w_held_r && !o_bvalid;
    assign wr_go     = aw_held_r && w_held_r && !o_bvalid;
    assign wr_hit    = wr_go && wstrb_r[0] && lfr_mapped(awaddr_r);
    assign wbyte     = wdata_r[7:0];

    // soft reset fires for the cycle the bit is written as one
    assign soft_reset_bit = wr_hit && (awaddr_r == `LFR_OFS_CTRL)
                            && wbyte[`LFR_CTRL_SWRES];

    // one strobe per writable register, so each write condition lives in one place
    assign wr_ctrl    = wr_hit && (awaddr_r == `LFR_OFS_CTRL);
    assign wr_inten   = wr_hit && (awaddr_r == `LFR_OFS_INTEN);
    assign wr_bittime = wr_hit && (awaddr_r == `LFR_OFS_BITTIME);
    assign wr_baud_lo = wr_hit && (awaddr_r == `LFR_OFS_BAUD_LO);
    assign wr_baud_hi = wr_hit && (awaddr_r == `LFR_OFS_BAUD_HI);
    assign wr_length  = wr_hit && (awaddr_r == `LFR_OFS_LENGTH);
    assign wr_ident   = wr_hit && (awaddr_r == `LFR_OFS_IDENT);
    assign wr_bufsel  = wr_hit && (awaddr_r == `LFR_OFS_BUFSEL);
    assign wr_data    = wr_hit && (awaddr_r == `LFR_OFS_DATA);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            awaddr_r  <= 8'h00;
            aw_held_r <= 1'b0;
        end else if (i_awvalid && o_awready) begin
            awaddr_r  <= i_awaddr;
            aw_held_r <= 1'b1;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            w_held_r <= 1'b0;
        end else if (i_wvalid && o_wready) begin
            wdata_r  <= i_wdata;
            wstrb_r  <= i_wstrb;
            w_held_r <= 1'b1;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // write answer phase; bvalid is the response state itself
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_state_r <= lfr_pkg::LFR_WR_IDLE;
        end else begin
            unique case (wr_state_r)
                lfr_pkg::LFR_WR_IDLE: begin
                    if (wr_go) begin
                        wr_state_r <= lfr_pkg::LFR_WR_RESP;
                    end
                end
                lfr_pkg::LFR_WR_RESP: begin
                    if (i_bready) begin
                        wr_state_r <= lfr_pkg::LFR_WR_IDLE;
                    end
                end
                // two codes of the state word are unused; recover to idle
                default: wr_state_r <= lfr_pkg::LFR_WR_IDLE;
            endcase
        end
    end
    assign o_bvalid = (wr_state_r == lfr_pkg::LFR_WR_RESP);

    // write response code, okay for mapped, slverr otherwise
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_bresp <= 2'h0;
        end else if (wr_go) begin
            o_bresp <= lfr_mapped(awaddr_r) ? 2'h0 : 2'h2;
        end
    end

    // control: soft reset bit never stored, so it reads back zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            controller_control_reg_r <= `LFR_RST_ZERO;
        end else if (soft_reset_bit) begin
            controller_control_reg_r <= `LFR_RST_ZERO;
        end else if (wr_ctrl) begin
            controller_control_reg_r <= wbyte & 8'h7f;
        end
    end

    // status, error and data clear on both resets
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            status_interrupt_reg_r <= `LFR_RST_ZERO;
            error_reg_r            <= `LFR_RST_ZERO;
            data_window_reg_r      <= `LFR_RST_ZERO;
        end else if (soft_reset_bit) begin
            status_interrupt_reg_r <= `LFR_RST_ZERO;
            error_reg_r            <= `LFR_RST_ZERO;
            data_window_reg_r      <= `LFR_RST_ZERO;
        end else if (wr_data) begin
            data_window_reg_r <= wbyte;
        end
    end

    // length register, cleared by both resets
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            frame_length_control_r <= `LFR_RST_ZERO;
        end else if (soft_reset_bit) begin
            frame_length_control_r <= `LFR_RST_ZERO;
        end else if (wr_length) begin
            frame_length_control_r <= wbyte;
        end
    end

    // interrupt enable: upper nibble left as is, its value is undefined
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            interrupt_enable_reg_r <= `LFR_RST_ZERO;
        end else if (soft_reset_bit) begin
            interrupt_enable_reg_r[3:0] <= 4'h0;
        end else if (wr_inten) begin
            interrupt_enable_reg_r <= wbyte;
        end
    end

    // bit timing back to its default on both resets
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            bit_timing_reg_r <= `LFR_RST_BITTIME;
        end else if (soft_reset_bit) begin
            bit_timing_reg_r <= `LFR_RST_BITTIME;
        end else if (wr_bittime) begin
            bit_timing_reg_r <= wbyte;
        end
    end

    // baud divisor survives soft reset so the link rate is kept
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            baud_divisor_low_r  <= `LFR_RST_ZERO;
            baud_divisor_high_r <= `LFR_RST_ZERO;
        end else if (soft_reset_bit) begin
            baud_divisor_low_r  <= baud_divisor_low_r;
        end else if (wr_baud_lo) begin
            baud_divisor_low_r  <= wbyte;
        end else if (wr_baud_hi) begin
            baud_divisor_high_r <= wbyte;
        end
    end

    // buffer select: low nibble cleared by soft reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            buffer_select_reg_r <= `LFR_RST_ZERO;
        end else if (soft_reset_bit) begin
            buffer_select_reg_r[3:0] <= 4'h0;
        end else if (wr_bufsel) begin
            buffer_select_reg_r <= wbyte;
        end
    end

    // identifier: only six bits stored, parity computed on read
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            id_value_r <= 6'h00;
        end else if (soft_reset_bit) begin
            id_value_r <= 6'h00;
        end else if (wr_ident) begin
            id_value_r <= wbyte[5:0];
        end
    end

    // protocol and mode decode
    assign uart_mode              = controller_control_reg_r[`LFR_CTRL_UART];
    assign legacy_protocol_select =
        controller_control_reg_r[`LFR_CTRL_LEGACY];
    // uart commands never look at the protocol bit
    assign cksum_kind = (!uart_mode && legacy_protocol_select)
                        ? lfr_pkg::LFR_CK_CLASSIC
                        : lfr_pkg::LFR_CK_ENHANCED;

    // parity over the six identifier bits
    assign id_parity_bits[0] = id_value_r[4] ^ id_value_r[2]
                             ^ id_value_r[1] ^ id_value_r[0];
    assign id_parity_bits[1] = ~(id_value_r[1] ^ id_value_r[3]
                             ^ id_value_r[4] ^ id_value_r[5]);
    // in uart mode the parity field is unused and reads zero
    assign ident_read = uart_mode ? {2'h0, id_value_r}
                        : {id_parity_bits, id_value_r};

    // legacy length code from identifier bits 5:4
    assign legacy_length_code = id_value_r[5:4];
    always_comb begin
        unique case (legacy_length_code)
            2'h0, 2'h1: legacy_len = 4'h2;
            2'h2:       legacy_len = 4'h4;
            2'h3:       legacy_len = 4'h8;
        endcase
    end

    // clamped byte counts from the length register
    assign tx_byte_count = lfr_clamp(frame_length_control_r[7:4]);
    assign rx_byte_count = lfr_clamp(frame_length_control_r[3:0]);

    // frame fields registered toward the tx and rx services
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_tx_len        <= 4'h0;
            o_rx_len        <= 4'h0;
            o_frame_id      <= 6'h00;
            o_lin_mode      <= 1'b1;
            o_cksum_classic <= 1'b0;
        end else if (uart_mode) begin
            o_tx_len        <= 4'h0;
            o_rx_len        <= 4'h0;
            o_frame_id      <= 6'h00;
            o_lin_mode      <= 1'b0;
            o_cksum_classic <= 1'b0;
        end else if (legacy_protocol_select) begin
            o_tx_len        <= tx_byte_count;
            o_rx_len        <= rx_byte_count;
            o_frame_id      <= {2'h0, id_value_r[3:0]};
            o_lin_mode      <= 1'b1;
            o_cksum_classic <= cksum_kind == lfr_pkg::LFR_CK_CLASSIC;
        end else begin
            o_tx_len        <= tx_byte_count;
            o_rx_len        <= rx_byte_count;
            o_frame_id      <= id_value_r;
            o_lin_mode      <= 1'b1;
            o_cksum_classic <= cksum_kind == lfr_pkg::LFR_CK_CLASSIC;
        end
    end

    // read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (i_araddr)
            `LFR_OFS_CTRL:    rd_word[7:0] = controller_control_reg_r;
            `LFR_OFS_STATUS:  rd_word[7:0] = status_interrupt_reg_r;
            `LFR_OFS_INTEN:   rd_word[7:0] = interrupt_enable_reg_r;
            `LFR_OFS_ERROR:   rd_word[7:0] = error_reg_r;
            `LFR_OFS_BITTIME: rd_word[7:0] = bit_timing_reg_r;
            `LFR_OFS_BAUD_LO: rd_word[7:0] = baud_divisor_low_r;
            `LFR_OFS_BAUD_HI: rd_word[7:0] = baud_divisor_high_r;
            `LFR_OFS_LENGTH:  rd_word[7:0] = frame_length_control_r;
            `LFR_OFS_IDENT:   rd_word[7:0] = ident_read;
            `LFR_OFS_BUFSEL:  rd_word[7:0] = buffer_select_reg_r;
            `LFR_OFS_DATA:    rd_word[7:0] = data_window_reg_r;
            `LFR_OFS_DECODE:  rd_word[15:0] = {legacy_len, o_frame_id,
                                               o_cksum_classic,
                                               o_lin_mode, 4'h0};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // read channel, one read at a time
    assign o_arready = !o_rvalid;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= 2'h0;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_word;
            o_rresp  <= lfr_mapped(i_araddr) ? 2'h0 : 2'h2;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule

// file: src/lfr_params.svh
// register offsets, field positions and reset values for the lin frame block
`ifndef LFR_PARAMS_SVH
`define LFR_PARAMS_SVH

`define LFR_OFS_CTRL      8'h00
`define LFR_OFS_STATUS    8'h04
`define LFR_OFS_INTEN     8'h08
`define LFR_OFS_ERROR     8'h0c
`define LFR_OFS_BITTIME   8'h10
`define LFR_OFS_BAUD_LO   8'h14
`define LFR_OFS_BAUD_HI   8'h18
`define LFR_OFS_LENGTH    8'h1c
`define LFR_OFS_IDENT     8'h20
`define LFR_OFS_BUFSEL    8'h24
`define LFR_OFS_DATA      8'h28
`define LFR_OFS_DECODE    8'h2c

`define LFR_CTRL_SWRES    7
`define LFR_CTRL_LEGACY   3
`define LFR_CTRL_UART     2

`define LFR_RST_ZERO      8'h00
`define LFR_RST_BITTIME   8'h20
`define LFR_RST_IDENT     8'h80

`define LFR_LEN_MAX       4'h8

`endif

// file: src/lfr_pkg.sv
// types shared by the lin frame block
package lfr_pkg;
    typedef enum logic [1:0] {
        LFR_WR_IDLE,
        LFR_WR_RESP
    } lfr_wr_state_t;

    typedef enum logic {
        LFR_CK_ENHANCED,
        LFR_CK_CLASSIC
    } lfr_cksum_t;
endpackage
